// ===== verilog/pdt_pwm_update.sv
// pwm update control, output override timing and dead-time configuration
`timescale 1ns/10ps
module pdt_pwm_update
    import pdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tb_boundary,
    input wire logic [1:0] pwm_raw,
    output logic [15:0] duty_active,
    output logic [15:0] period_active,
    output logic [1:0] pwm_h,
    output logic [1:0] pwm_l
);

    typedef struct packed {
        logic [2:0] ctrl2;
        logic [15:0] dtcon1;
        logic [15:0] duty_buf;
        logic [15:0] duty_act;
        logic [15:0] per_buf;
        logic [15:0] per_act;
        logic [7:0] ovr_buf;
        logic [7:0] ovr_act;
        logic [1:0] pin_h;
        logic [1:0] pin_l;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pdt_state_s;

    pdt_state_s st_r;
    pdt_state_s st_nxt;

    logic setup;
    logic access;
    logic wr;
    logic mapped;
    logic wr_ctrl2;
    logic wr_dtcon1;
    logic wr_duty;
    logic wr_per;
    logic wr_ovr;
    logic immediate_duty_update;
    logic override_sync_select;
    logic buffer_update_disable;
    logic [31:0] rd_val;
    logic [1:0] dt_h;
    logic [1:0] dt_l;
    pdt_dt_cfg_s cfg_a;
    pdt_dt_cfg_s cfg_b;
    pdt_dt_cfg_s [1:0] cfg;

    assign immediate_duty_update = st_r.ctrl2[PDT_BIT_IUE];
    assign override_sync_select = st_r.ctrl2[PDT_BIT_OVERRIDE_SYNC_SELECT];
    assign buffer_update_disable = st_r.ctrl2[PDT_BIT_BUFFER_UPDATE_DISABLE];

    // field split of the dead-time register
    assign cfg_a.prescale =
        st_r.dtcon1[PDT_DTA_PS_LSB +: PDT_DT_PS_W];
    assign cfg_a.count =
        st_r.dtcon1[PDT_DTA_CNT_LSB +: PDT_DT_CNT_W];
    assign cfg_b.prescale =
        st_r.dtcon1[PDT_DTB_PS_LSB +: PDT_DT_PS_W];
    assign cfg_b.count =
        st_r.dtcon1[PDT_DTB_CNT_LSB +: PDT_DT_CNT_W];
    assign cfg[0] = cfg_a;
    assign cfg[1] = cfg_b;

    // unit a serves pair 0, unit b serves pair 1
    genvar gi;
    generate
        for (gi = 0; gi < PDT_PAIRS; gi++) begin : g_dt
            pdt_dt_unit u_dt (
                .pclk(pclk),
                .presetn(presetn),
                .raw(pwm_raw[gi]),
                .cfg(cfg[gi]),
                .out_h(dt_h[gi]),
                .out_l(dt_l[gi])
            );
        end
    endgenerate

    // apb decode; the read value is captured in the setup cycle
    always_comb begin
        setup = psel && !penable;
        access = psel && penable && st_r.pready;
        wr = access && pwrite;
        wr_ctrl2 = wr && (paddr == PDT_OFF_CTRL2);
        wr_dtcon1 = wr && (paddr == PDT_OFF_DTCON1);
        wr_duty = wr && (paddr == PDT_OFF_DUTY_BUF);
        wr_per = wr && (paddr == PDT_OFF_PER_BUF);
        wr_ovr = wr && (paddr == PDT_OFF_OVR_BUF);
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            PDT_OFF_CTRL2: begin
                rd_val = {29'h0, st_r.ctrl2};
            end
            PDT_OFF_DTCON1: begin
                rd_val = {16'h0, st_r.dtcon1};
            end
            PDT_OFF_DUTY_BUF: begin
                rd_val = {16'h0, st_r.duty_buf};
            end
            PDT_OFF_DUTY_ACT: begin
                rd_val = {16'h0, st_r.duty_act};
            end
            PDT_OFF_PER_BUF: begin
                rd_val = {16'h0, st_r.per_buf};
            end
            PDT_OFF_PER_ACT: begin
                rd_val = {16'h0, st_r.per_act};
            end
            PDT_OFF_OVR_BUF: begin
                rd_val = {24'h0, st_r.ovr_buf};
            end
            PDT_OFF_OVR_ACT: begin
                rd_val = {24'h0, st_r.ovr_act};
            end
            default: begin
                mapped = 1'b0;
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // next-state logic for registers, transfers and pins
    always_comb begin
        st_nxt = st_r;

        // zero wait states: ready rises for the single access cycle
        st_nxt.pready = setup;
        if (setup) begin
            st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
            st_nxt.pslverr = !mapped;
        end else if (access) begin
            st_nxt.pslverr = 1'b0;
        end

        // software writes to the control and buffer registers
        if (wr_ctrl2) begin
            st_nxt.ctrl2 = pwdata[PDT_CTRL2_W-1:0];
        end
        if (wr_dtcon1) begin
            st_nxt.dtcon1 = pwdata[PDT_REG_W-1:0];
        end
        if (wr_duty) begin
            st_nxt.duty_buf = pwdata[PDT_REG_W-1:0];
        end
        if (wr_per) begin
            st_nxt.per_buf = pwdata[PDT_REG_W-1:0];
        end
        if (wr_ovr) begin
            st_nxt.ovr_buf = pwdata[PDT_OVR_W-1:0];
        end

        // boundary transfers; a write in the same cycle stays pending
        if (tb_boundary && !buffer_update_disable) begin
            st_nxt.per_act = st_r.per_buf;
            if (!immediate_duty_update) begin
                st_nxt.duty_act = st_r.duty_buf;
            end
        end

        // immediate mode bypasses the buffer, still obeying the freeze
        if (immediate_duty_update && !buffer_update_disable && wr_duty) begin
            st_nxt.duty_act = pwdata[PDT_REG_W-1:0];
        end

        // override timing
        if (override_sync_select) begin
            if (tb_boundary) begin
                st_nxt.ovr_act = st_r.ovr_buf;
            end
        end else if (wr_ovr) begin
            st_nxt.ovr_act = pwdata[PDT_OVR_W-1:0];
        end else begin
            st_nxt.ovr_act = st_r.ovr_buf;
        end

        // pin layout in the override: l0, h0, l1, h1 from bit 0 up
        for (int i = 0; i < PDT_PAIRS; i++) begin
            if (st_r.ovr_act[PDT_OVR_EN_LSB + 2*i]) begin
                st_nxt.pin_l[i] = st_r.ovr_act[2*i];
            end else begin
                st_nxt.pin_l[i] = dt_l[i];
            end
            if (st_r.ovr_act[PDT_OVR_EN_LSB + 2*i + 1]) begin
                st_nxt.pin_h[i] = st_r.ovr_act[2*i + 1];
            end else begin
                st_nxt.pin_h[i] = dt_h[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.ctrl2 <= PDT_CTRL2_RST;
            st_r.dtcon1 <= PDT_DTCON1_RST;
            st_r.duty_buf <= PDT_DUTY_RST;
            st_r.duty_act <= PDT_DUTY_RST;
            st_r.per_buf <= PDT_PER_RST;
            st_r.per_act <= PDT_PER_RST;
            st_r.ovr_buf <= PDT_OVR_RST;
            st_r.ovr_act <= PDT_OVR_RST;
            st_r.pin_h <= 2'h0;
            st_r.pin_l <= 2'h0;
            st_r.pready <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.prdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign duty_active = st_r.duty_act;
    assign period_active = st_r.per_act;
    assign pwm_h = st_r.pin_h;
    assign pwm_l = st_r.pin_l;

    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");

    imm_duty_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_duty && immediate_duty_update && !buffer_update_disable |=> duty_active == $past(pwdata[15:0]))
        else $error("immediate duty write not applied");

    sync_duty_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        $changed(duty_active) && !$past(immediate_duty_update) |-> $past(tb_boundary))
        else $error("duty changed away from a boundary");

    ovr_sync_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        $changed(st_r.ovr_act) && $past(override_sync_select) |-> $past(tb_boundary))
        else $error("synchronised override changed off boundary");

    ovr_next_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_ovr && !override_sync_select |=> st_r.ovr_act == $past(pwdata[7:0]))
        else $error("override not applied on next cycle");

    upd_dis_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        $past(buffer_update_disable) |-> $stable(period_active) && $stable(duty_active))
        else $error("active value moved while updates disabled");

    rsv_zero_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        access && !pwrite && paddr == PDT_OFF_CTRL2 |-> prdata[31:3] == 29'h0)
        else $error("unimplemented control bits read nonzero");

    dt_write_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_dtcon1 |=> cfg_b.count == $past(pwdata[13:8])
            && cfg_a.prescale == $past(pwdata[7:6]))
        else $error("dead-time fields not stored");

    dt_read_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        access && !pwrite && paddr == PDT_OFF_DTCON1
            |-> prdata[15:0] == st_r.dtcon1)
        else $error("dead-time register read mismatch");

    per_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        tb_boundary && !buffer_update_disable |=> period_active == $past(st_r.per_buf))
        else $error("period buffer not moved at the boundary");

    duty_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        tb_boundary && !buffer_update_disable && !immediate_duty_update |=> duty_active == $past(st_r.duty_buf))
        else $error("duty buffer not moved at the boundary");

    imm_block_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_duty && buffer_update_disable |=> $stable(duty_active))
        else $error("duty write went active while frozen");

    imm_skip_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        tb_boundary && immediate_duty_update && !wr_duty |=> $stable(duty_active))
        else $error("boundary reloaded duty in immediate mode");

    ovr_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        override_sync_select && tb_boundary |=> st_r.ovr_act == $past(st_r.ovr_buf))
        else $error("synchronised override not loaded at boundary");

    ovr_follow_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !override_sync_select && !wr_ovr |=> st_r.ovr_act == $past(st_r.ovr_buf))
        else $error("unsynchronised override lags its buffer");

    ctrl_store_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_ctrl2 |=> st_r.ctrl2 == $past(pwdata[2:0]))
        else $error("control bits not stored");

    dt_store_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_dtcon1 |=> cfg_a.count == $past(pwdata[5:0])
            && cfg_b.prescale == $past(pwdata[15:14]))
        else $error("dead-time count or prescale not stored");

    bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

    pin_ovr_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        st_r.ovr_act[PDT_OVR_EN_LSB] |=> pwm_l[0] == $past(st_r.ovr_act[0]))
        else $error("overridden pin does not follow override");

    pin_dt_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !st_r.ovr_act[PDT_OVR_EN_LSB + 1] |=> pwm_h[0] == $past(dt_h[0]))
        else $error("free pin does not follow dead-time unit");

endmodule

// ===== verilog/pdt_pkg.sv
// shared constants and carrier types for the pwm update and dead-time block
package pdt_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] PDT_OFF_CTRL2 = 8'h00;
    localparam logic [7:0] PDT_OFF_DTCON1 = 8'h04;
    localparam logic [7:0] PDT_OFF_DUTY_BUF = 8'h08;
    localparam logic [7:0] PDT_OFF_DUTY_ACT = 8'h0c;
    localparam logic [7:0] PDT_OFF_PER_BUF = 8'h10;
    localparam logic [7:0] PDT_OFF_PER_ACT = 8'h14;
    localparam logic [7:0] PDT_OFF_OVR_BUF = 8'h18;
    localparam logic [7:0] PDT_OFF_OVR_ACT = 8'h1c;

    // pwm_control_2 field positions
    localparam int PDT_CTRL2_W = 3;
    localparam int PDT_BIT_BUFFER_UPDATE_DISABLE = 0;
    localparam int PDT_BIT_OVERRIDE_SYNC_SELECT = 1;
    localparam int PDT_BIT_IUE = 2;

    // dead_time_control_1 field positions
    localparam int PDT_DTA_CNT_LSB = 0;
    localparam int PDT_DTA_PS_LSB = 6;
    localparam int PDT_DTB_CNT_LSB = 8;
    localparam int PDT_DTB_PS_LSB = 14;
    localparam int PDT_DT_CNT_W = 6;
    localparam int PDT_DT_PS_W = 2;

    // widths
    localparam int PDT_REG_W = 16;
    localparam int PDT_OVR_W = 8;
    localparam int PDT_OVR_EN_LSB = 4;
    localparam int PDT_PAIRS = 2;
    localparam int PDT_PS_CNT_W = 3;

    // reset values
    localparam logic [2:0] PDT_CTRL2_RST = 3'h0;
    localparam logic [15:0] PDT_DTCON1_RST = 16'h0000;
    localparam logic [15:0] PDT_DUTY_RST = 16'h0000;
    localparam logic [15:0] PDT_PER_RST = 16'h0000;
    localparam logic [7:0] PDT_OVR_RST = 8'h00;

    // configuration of one dead-time unit
    typedef struct packed {
        logic [1:0] prescale;
        logic [5:0] count;
    } pdt_dt_cfg_s;

endpackage

// ===== verilog/pdt_presc.sv
// prescaler giving a tick every 1, 2, 4 or 8 clock cycles
`timescale 1ns/10ps
module pdt_presc
    import pdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [1:0] code,
    output logic tick
);

    typedef struct packed {
        logic [2:0] cnt;
    } pdt_presc_state_s;

    pdt_presc_state_s st_r;
    pdt_presc_state_s st_nxt;
    logic [2:0] lim;

    // period is 2**code cycles, so the last count is 2**code - 1
    always_comb begin
        lim = 3'(({3'h0, 1'b1} << code) - 4'h1);
        tick = !clear && (st_r.cnt == lim);
        st_nxt = st_r;
        if (clear || tick) begin
            st_nxt.cnt = 3'h0;
        end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{cnt: 3'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    tick_space_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        tick && code == 2'h3 |=> (!tick || code != 2'h3)[*7])
        else $error("prescale tick came early for code 3");

endmodule

// ===== verilog/pdt_dt_unit.sv
// one dead-time unit driving a complementary output pair
`timescale 1ns/10ps
module pdt_dt_unit
    import pdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw,
    input wire pdt_dt_cfg_s cfg,
    output logic out_h,
    output logic out_l
);

    typedef struct packed {
        logic prev;
        logic h;
        logic l;
        logic busy;
        logic [5:0] cnt;
    } pdt_dt_state_s;

    pdt_dt_state_s st_r;
    pdt_dt_state_s st_nxt;
    logic clr;
    logic tick;

    pdt_presc u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .clear(clr),
        .code(cfg.prescale),
        .tick(tick)
    );

    // any edge of the raw signal drops both sides, then waits out the gap
    always_comb begin
        st_nxt = st_r;
        clr = 1'b0;
        if (raw != st_r.prev) begin
            st_nxt.prev = raw;
            st_nxt.h = 1'b0;
            st_nxt.l = 1'b0;
            st_nxt.cnt = cfg.count;
            st_nxt.busy = 1'b1;
            clr = 1'b1;
        end else if (st_r.busy) begin
            if (st_r.cnt == 6'h00) begin
                st_nxt.busy = 1'b0;
                st_nxt.h = st_r.prev;
                st_nxt.l = !st_r.prev;
            end else if (tick) begin
                st_nxt.cnt = st_r.cnt - 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{prev: 1'b0, h: 1'b0, l: 1'b0, busy: 1'b1, cnt: 6'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_h = st_r.h;
    assign out_l = st_r.l;

    no_overlap_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !(st_r.h && st_r.l))
        else $error("both sides of the pair active together");

    gap_before_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        $rose(st_r.h) || $rose(st_r.l) |-> $past(!st_r.h && !st_r.l))
        else $error("output asserted without a dead gap");

endmodule

// ===== tb/pdt_pwm_update_tb.sv
// self-checking bench for the pwm update and dead-time block
`timescale 1ns/10ps
module pdt_pwm_update_tb
    import pdt_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic tb_boundary;
    logic [1:0] pwm_raw, pwm_h, pwm_l;
    logic [15:0] duty_active, period_active;
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] q;
    logic e;

    pdt_pwm_update i_pdt_pwm_update (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tb_boundary(tb_boundary),
        .pwm_raw(pwm_raw), .duty_active(duty_active),
        .period_active(period_active), .pwm_h(pwm_h), .pwm_l(pwm_l)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one transfer, then one idle edge so psel is never assigned twice
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // look between edges; the next rising edge completes the access
        @(negedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 50)
            check(32'h0, 32'h1);
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask

    task boundary;
        tb_boundary <= 1'b1;
        @(posedge pclk);
        tb_boundary <= 1'b0;
        @(posedge pclk);
    endtask

    // measure the gap from a raw rise to the high side turning on
    task dt(input int u, input logic [1:0] ps, input logic [5:0] c);
        int n, gap;
        logic ovl, ok;
        gap = int'(c) << ps;
        wr(PDT_OFF_DTCON1, (u == 1) ? {16'h0, ps, c, 8'h00}
                                    : {24'h0, ps, c});
        n = 0;
        @(negedge pclk);
        while (pwm_l[u] !== 1'b1 && n < 1000) begin
            @(negedge pclk);
            n++;
        end
        check({31'h0, pwm_l[u]}, 32'h1);
        @(posedge pclk);
        pwm_raw[u] <= 1'b1;
        n = 0;
        ovl = 1'b0;
        do begin
            @(negedge pclk);
            n++;
            if (n > 2 && pwm_l[u] === 1'b1)
                ovl = 1'b1;
        end while (pwm_h[u] !== 1'b1 && n < 1000);
        ok = (n >= gap && n <= gap + 6);
        check({31'h0, ovl}, 32'h0);
        check({31'h0, ok}, 32'h1);
        @(posedge pclk);
        pwm_raw[u] <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        #200000;
        check(32'h0, 32'h1);
        final_report();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tb_boundary = 1'b0;
        pwm_raw = 2'b00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(PDT_OFF_CTRL2, 32'h0);
        rc(PDT_OFF_DTCON1, 32'h0);
        wr(PDT_OFF_CTRL2, 32'hffff_ffff);
        rc(PDT_OFF_CTRL2, 32'h7);
        wr(PDT_OFF_DTCON1, 32'h0000_a5c3);
        rc(PDT_OFF_DTCON1, 32'ha5c3);
        wr(PDT_OFF_DTCON1, 32'h0000_5a3c);
        rc(PDT_OFF_DTCON1, 32'h5a3c);
        rc(8'h40, 32'h0);
        check({31'h0, e}, 32'h1);
        // buffered duty waits for the time base
        wr(PDT_OFF_CTRL2, 32'h0);
        wr(PDT_OFF_DUTY_BUF, 32'h1234);
        wr(PDT_OFF_PER_BUF, 32'h0055);
        check({16'h0, duty_active}, 32'h0);
        boundary();
        check({16'h0, duty_active}, 32'h1234);
        check({16'h0, period_active}, 32'h0055);
        wr(PDT_OFF_PER_ACT, 32'h0077);
        check({31'h0, e}, 32'h0);
        rc(PDT_OFF_PER_ACT, 32'h0055);
        // immediate duty goes active with the write
        wr(PDT_OFF_CTRL2, 32'h4);
        wr(PDT_OFF_DUTY_BUF, 32'h4321);
        check({16'h0, duty_active}, 32'h4321);
        // transfers frozen while disabled
        wr(PDT_OFF_CTRL2, 32'h1);
        wr(PDT_OFF_DUTY_BUF, 32'h0abc);
        wr(PDT_OFF_PER_BUF, 32'h0099);
        boundary();
        check({16'h0, duty_active}, 32'h4321);
        check({16'h0, period_active}, 32'h0055);
        // frozen immediate write lands only in the buffer
        wr(PDT_OFF_CTRL2, 32'h5);
        wr(PDT_OFF_DUTY_BUF, 32'h0abc);
        check({16'h0, duty_active}, 32'h4321);
        // boundary leaves the duty alone in immediate mode
        wr(PDT_OFF_CTRL2, 32'h4);
        boundary();
        check({16'h0, duty_active}, 32'h4321);
        check({16'h0, period_active}, 32'h0099);
        wr(PDT_OFF_CTRL2, 32'h0);
        boundary();
        check({16'h0, duty_active}, 32'h0abc);
        check({16'h0, period_active}, 32'h0099);
        // override applied at once when unsynchronised
        wr(PDT_OFF_OVR_BUF, 32'hf6);
        repeat (3) @(posedge pclk);
        check({28'h0, pwm_h, pwm_l}, 32'h6);
        // synchronised override holds off until the boundary
        wr(PDT_OFF_CTRL2, 32'h2);
        wr(PDT_OFF_OVR_BUF, 32'hf9);
        repeat (3) @(posedge pclk);
        rc(PDT_OFF_OVR_ACT, 32'hf6);
        check({28'h0, pwm_h, pwm_l}, 32'h6);
        boundary();
        repeat (3) @(posedge pclk);
        check({28'h0, pwm_h, pwm_l}, 32'h9);
        wr(PDT_OFF_CTRL2, 32'h0);
        wr(PDT_OFF_OVR_BUF, 32'h00);
        // every prescale code on both units, plus the largest count
        for (int u = 0; u < 2; u++) begin
            for (int p = 0; p < 4; p++) begin
                dt(u, p[1:0], 6'd5);
            end
        end
        dt(1, 2'b11, 6'h3f);
        dt(0, 2'b11, 6'h3f);
        // a second reset clears the dead-time register
        wr(PDT_OFF_DTCON1, 32'h0000_ffff);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(PDT_OFF_DTCON1, 32'h0);
        final_report();
    end
endmodule
